/* design/psc_host.sv */
`timescale 1ns/1ps
`default_nettype none
module psc_host
  import psc_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  psc_if.host lnk
);
  psc_hstate_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic mode_r;
  logic [5:0] word_r, par_r, rb_r, rb_nxt;
  logic sdo_s1_r, sdo_s2_r;
  logic pready_r, pslverr_r;
  logic [31:0] prdata_r;
  logic sel_r, le_r, sck_r, sdi_r;
  logic [2:0] hi_r;
  logic le_nxt, sck_nxt, sdi_nxt;

  // Bus decode
  wire acc = psel & penable;
  wire wr_en = acc & pwrite & pready_r;
  wire hit_ctrl = (paddr == PSC_OFS_CTRL);
  wire hit_word = (paddr == PSC_OFS_WORD);
  wire hit_par = (paddr == PSC_OFS_PAR);
  wire hit_stat = (paddr == PSC_OFS_STAT);
  wire hit_any = hit_ctrl | hit_word | hit_par | hit_stat;
  wire busy = (st_r != PSC_H_IDLE);
  wire go = wr_en & hit_ctrl & pwdata[PSC_CTRL_GO_BIT] & ~busy
            & pwdata[PSC_CTRL_MODE_BIT] & mode_r;
  wire cnt_done = (cnt_r == 5'd0);
  wire [31:0] rdata = hit_ctrl ? {31'h0, mode_r} :
                      hit_word ? {26'h0, word_r} :
                      hit_par ? {26'h0, par_r} :
                      hit_stat ? {18'h0, rb_r, 7'h0, busy} : 32'h0;

  // One wait state, then answer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0;
    end else begin
      pready_r <= acc & ~pready_r;
      pslverr_r <= acc & ~pready_r & ~hit_any;
      prdata_r <= (acc & ~pready_r & ~pwrite) ? rdata : 32'h0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_r <= PSC_MODE_RST;
      word_r <= PSC_WORD_RST;
      par_r <= PSC_PAR_RST;
    end else if (wr_en) begin
      if (hit_ctrl) mode_r <= pwdata[PSC_CTRL_MODE_BIT];
      if (hit_word) word_r <= pwdata[5:0];
      if (hit_par) par_r <= pwdata[5:0];
    end
  end

  // Chain output crosses in through two flops
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo_s1_r <= 1'b0;
      sdo_s2_r <= 1'b0;
    end else begin
      sdo_s1_r <= lnk.shift_data_out;
      sdo_s2_r <= sdo_s1_r;
    end
  end

  // Shift sequencer
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_done ? 5'd0 : cnt_r - 5'd1;
    bit_nxt = bit_r;
    rb_nxt = rb_r;
    le_nxt = 1'b0;
    sck_nxt = 1'b0;
    sdi_nxt = sdi_r;
    case (st_r)
      PSC_H_IDLE: begin
        if (go) begin
          st_nxt = PSC_H_LOW;
          cnt_nxt = 5'(PSC_SCK_HALF_CYC - 1);
          bit_nxt = 3'd0;
          sdi_nxt = word_r[5];
        end
      end
      PSC_H_LOW: begin
        if (cnt_done) begin
          st_nxt = PSC_H_HIGH;
          sck_nxt = 1'b1;
          rb_nxt = {rb_r[4:0], sdo_s2_r};
          cnt_nxt = 5'(PSC_SCK_HALF_CYC - 1);
        end
      end
      PSC_H_HIGH: begin
        sck_nxt = ~cnt_done;
        if (cnt_done) begin
          bit_nxt = bit_r + 3'd1;
          if (bit_r == 3'(PSC_WORD_W - 1)) begin
            st_nxt = PSC_H_STROBE;
            le_nxt = 1'b1;
            cnt_nxt = 5'(PSC_LE_W_CYC - 1);
          end else begin
            st_nxt = PSC_H_LOW;
            sdi_nxt = word_r[3'd4 - bit_r];
            cnt_nxt = 5'(PSC_SCK_HALF_CYC - 1);
          end
        end
      end
      PSC_H_STROBE: begin
        le_nxt = ~cnt_done;
        if (cnt_done) begin
          st_nxt = PSC_H_GAP;
          cnt_nxt = 5'(PSC_LE_SPACE_CYC - PSC_LE_W_CYC - 1);
        end
      end
      PSC_H_GAP: begin
        if (cnt_done) st_nxt = PSC_H_IDLE;
      end
      default: st_nxt = PSC_H_IDLE;
    endcase
    if (!mode_r) st_nxt = PSC_H_IDLE;
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= PSC_H_IDLE;
      cnt_r <= 5'd0;
      bit_r <= 3'd0;
      rb_r <= PSC_WORD_RST;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      bit_r <= bit_nxt;
      rb_r <= rb_nxt;
    end
  end

  // Pins: shared pins carry serial controls in serial mode, parallel bits otherwise; high bits always parallel
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sel_r <= PSC_MODE_RST;
      le_r <= 1'b0;
      sck_r <= 1'b0;
      sdi_r <= 1'b0;
      hi_r <= 3'h0;
    end else begin
      sel_r <= mode_r;
      le_r <= mode_r ? le_nxt : par_r[2];
      sck_r <= mode_r ? sck_nxt : par_r[1];
      sdi_r <= mode_r ? sdi_nxt : par_r[0];
      hi_r <= par_r[5:3];
    end
  end

  assign lnk.ps_sel = sel_r;
  assign lnk.load_strobe = le_r;
  assign lnk.shift_clk = sck_r;
  assign lnk.shift_data_in = sdi_r;
  assign lnk.phase_hi = hi_r;
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
endmodule : psc_host
`default_nettype wire

/* design/psc_pkg.sv */
package psc_pkg;
  // Word and pin layout
  localparam int PSC_WORD_W = 6;
  localparam int PSC_HI_W = 3;
  // Timing, figures in ns and derived core cycles
  localparam int PSC_CORE_NS = 40;
  localparam int PSC_SCK_MIN_NS = 100;
  localparam int PSC_LE_W_NS = 10;
  localparam int PSC_LE_SPACE_NS = 630;
  localparam int PSC_SCK_HALF_CYC =
    (PSC_SCK_MIN_NS + 2 * PSC_CORE_NS - 1) / (2 * PSC_CORE_NS);
  localparam int PSC_LE_W_CYC_RAW =
    (PSC_LE_W_NS + PSC_CORE_NS - 1) / PSC_CORE_NS;
  localparam int PSC_LE_W_CYC = (PSC_LE_W_CYC_RAW < 1) ? 1 : PSC_LE_W_CYC_RAW;
  localparam int PSC_LE_SPACE_CYC =
    (PSC_LE_SPACE_NS + PSC_CORE_NS - 1) / PSC_CORE_NS;
  // Register offsets
  localparam logic [7:0] PSC_OFS_CTRL = 8'h00;
  localparam logic [7:0] PSC_OFS_WORD = 8'h04;
  localparam logic [7:0] PSC_OFS_PAR = 8'h08;
  localparam logic [7:0] PSC_OFS_STAT = 8'h0c;
  // Field positions
  localparam int PSC_CTRL_MODE_BIT = 0;
  localparam int PSC_CTRL_GO_BIT = 1;
  localparam int PSC_STAT_BUSY_BIT = 0;
  localparam int PSC_STAT_RB_LSB = 8;
  // Reset values
  localparam logic PSC_MODE_RST = 1'b1;
  localparam logic [5:0] PSC_WORD_RST = 6'h00;
  localparam logic [5:0] PSC_PAR_RST = 6'h00;
  localparam logic [5:0] PSC_STATE_RST = 6'h00;
  // Host sequencer states
  typedef enum logic [2:0] {
    PSC_H_IDLE = 3'b000,
    PSC_H_LOW = 3'b001,
    PSC_H_HIGH = 3'b010,
    PSC_H_STROBE = 3'b011,
    PSC_H_GAP = 3'b100
  } psc_hstate_t;
endpackage : psc_pkg

/* design/psc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface psc_if;
  // Mode select, shared control pins and upper parallel bits
  logic ps_sel;
  logic load_strobe;
  logic shift_clk;
  logic shift_data_in;
  logic [2:0] phase_hi;
  // Chain output
  logic shift_data_out;
  modport host (
    output ps_sel,
    output load_strobe,
    output shift_clk,
    output shift_data_in,
    output phase_hi,
    input shift_data_out
  );
  modport dev (
    input ps_sel,
    input load_strobe,
    input shift_clk,
    input shift_data_in,
    input phase_hi,
    output shift_data_out
  );
endinterface : psc_if
`default_nettype wire

/* design/psc_device.sv */
// Operation
// - Select high runs the serial interface
// - Host shifts six bits, MSB first
// - Strobe rising edge applies the shifted word
// - Shift clock ignored while strobe is high
// - Serial out is input delayed six clocks
// - Select low disables the serial interface
// - Applied state holds while strobe stays low
// - Shared pins are strobe/clock/data or D3/D2/D1
// - Select low follows parallel bits continuously
// - Binary weighted phase bits, 5.6 to 180
// - Host keeps shift clock period >= 100 ns
// - Strobe >= 10 ns wide, 630 ns apart
`timescale 1ns/1ps
`default_nettype none
module psc_device
  import psc_pkg::*;
(
  // Reset
  input wire logic reset_n,
  // Link
  psc_if.dev lnk,
  // Phase state
  output logic [PSC_WORD_W-1:0] phase_state,
  output logic serial_mode
);
  logic [PSC_WORD_W-1:0] chain_r;
  logic [PSC_WORD_W-1:0] applied_r;
  logic shift_en;
  logic [PSC_WORD_W-1:0] par_word;

  // Clock masked by strobe, and unused in parallel mode
  assign shift_en = lnk.ps_sel & ~lnk.load_strobe;

  // Pins 3..1 double as strobe, clock and data
  assign par_word = {lnk.phase_hi, lnk.load_strobe, lnk.shift_clk,
                     lnk.shift_data_in};

  // Six-stage chain, sampled on the rising shift clock
  always_ff @(posedge lnk.shift_clk or negedge reset_n) begin
    if (!reset_n) begin
      chain_r <= PSC_STATE_RST;
    end else if (shift_en) begin
      chain_r <= {chain_r[PSC_WORD_W-2:0], lnk.shift_data_in};
    end
  end

  assign lnk.shift_data_out = chain_r[PSC_WORD_W-1];

  // Word applied only on the strobe's rising edge
  always_ff @(posedge lnk.load_strobe or negedge reset_n) begin
    if (!reset_n) begin
      applied_r <= PSC_STATE_RST;
    end else if (lnk.ps_sel) begin
      applied_r <= chain_r;
    end
  end

  // Bit 0 weighs 5.6 degrees up to bit 5 at 180
  assign phase_state = lnk.ps_sel ? applied_r : par_word;
  assign serial_mode = lnk.ps_sel;
endmodule : psc_device
`default_nettype wire

/* dv/psc_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module psc_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Link pins
  input wire logic ps_sel,
  input wire logic load_strobe,
  input wire logic shift_clk,
  input wire logic shift_data_in,
  input wire logic [2:0] phase_hi,
  input wire logic shift_data_out,
  // Device state
  input wire logic [5:0] phase_state,
  input wire logic serial_mode
);
  logic [5:0] chain_r;
  logic [3:0] cnt_r;
  logic [4:0] gap_r;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Expected chain, shifted only while serial and unmasked
  always_ff @(posedge shift_clk or negedge reset_n) begin
    if (!reset_n) chain_r <= 6'h00;
    else if (ps_sel && !load_strobe) chain_r <= {chain_r[4:0], shift_data_in};
  end
  // Shift edges since the last strobe
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) cnt_r <= 4'h0;
    else if (ps_sel && $rose(load_strobe)) cnt_r <= 4'h0;
    else if (ps_sel && $rose(shift_clk)) cnt_r <= cnt_r + 4'h1;
  end
  // Core cycles since the last strobe rise, saturating
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) gap_r <= 5'h1f;
    else if (ps_sel && $rose(load_strobe)) gap_r <= 5'h00;
    else if (gap_r != 5'h1f) gap_r <= gap_r + 5'h01;
  end
  property p_mode; serial_mode == ps_sel; endproperty
  a_mode: assert property (p_mode)
    else $error("mode flag differs from select");
  property p_par;
    !ps_sel |-> phase_state == {phase_hi, load_strobe, shift_clk, shift_data_in};
  endproperty
  a_par: assert property (p_par)
    else $error("parallel state differs from pins");
  property p_hold;
    ps_sel && $past(ps_sel) && !load_strobe |-> $stable(phase_state);
  endproperty
  a_hold: assert property (p_hold)
    else $error("applied state moved with strobe low");
  property p_apply; ps_sel && $rose(load_strobe) |-> phase_state == chain_r;
  endproperty
  a_apply: assert property (p_apply)
    else $error("strobe applied a wrong word");
  property p_sout; shift_data_out == chain_r[5]; endproperty
  a_sout: assert property (p_sout)
    else $error("serial out is not the chain end");
  property p_cnt; ps_sel && $rose(load_strobe) |-> cnt_r == 4'h6; endproperty
  a_cnt: assert property (p_cnt)
    else $error("strobe without six shift clocks");
  property p_clk;
    ps_sel && $rose(shift_clk) |-> shift_clk [*2] ##1 !shift_clk [*2];
  endproperty
  a_clk: assert property (p_clk)
    else $error("shift clock period too short");
  property p_space;
    ps_sel && $rose(load_strobe) |-> gap_r >= 5'h0f;
  endproperty
  a_space: assert property (p_space)
    else $error("strobes too close together");
endmodule : psc_monitor
`default_nettype wire

/* dv/phase_shifter_control_port_test.sv */
`timescale 1ns/1ps
`default_nettype none
module phase_shifter_control_port_test
  import psc_pkg::*;
;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [5:0] phase_state;
  logic serial_mode;
  logic [33:0] rd_q[$];
  logic [5:0] ph_q[$];
  logic [5:0] prv = 6'h00;
  logic [31:0] r;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  integer seed = 32'h76f14766;
  always #20 core_clk = ~core_clk;
  psc_if psc_if_inst ();
  psc_host psc_host_inst (.core_clk(core_clk), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lnk(psc_if_inst.host));
  psc_device psc_device_inst (.reset_n(reset_n), .lnk(psc_if_inst.dev),
    .phase_state(phase_state), .serial_mode(serial_mode));
  psc_monitor psc_monitor_inst (.core_clk(core_clk), .reset_n(reset_n),
    .ps_sel(psc_if_inst.ps_sel), .load_strobe(psc_if_inst.load_strobe),
    .shift_clk(psc_if_inst.shift_clk),
    .shift_data_in(psc_if_inst.shift_data_in),
    .phase_hi(psc_if_inst.phase_hi),
    .shift_data_out(psc_if_inst.shift_data_out),
    .phase_state(phase_state), .serial_mode(serial_mode));
  task automatic stop_test;
    $display("Errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [33:0] e, input logic [33:0] g);
    compares++;
    if (e !== g) begin
      error_cnt++;
      $display("[ERR] %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic c, input logic [32:0] e);
    rd_q.push_back({c, e});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic send(input logic [5:0] w);
    apb(1'b1, PSC_OFS_WORD, {26'h0, w});
    apb(1'b1, PSC_OFS_CTRL, 32'h3);
    do rd(PSC_OFS_STAT, 1'b0, 33'h0); while (r[0] !== 1'b0);
    ph_q.push_back(w);
    rd(PSC_OFS_STAT, 1'b1, {1'b0, 18'h0, prv, 8'h00});
    prv = w;
  endtask : send
  // Cycle limit
  always @(posedge core_clk) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      stop_test();
    end
  end
  // Result watcher
  always @(posedge core_clk) begin : watch
    logic [33:0] e;
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      e = rd_q.pop_front();
      if (e[33]) begin
        chk({1'b0, e[32:0]}, {1'b0, pslverr, prdata});
      end
    end
    if (ph_q.size() > 0) begin
      chk({28'h0, ph_q.pop_front()}, {28'h0, phase_state});
    end
  end
  initial begin
    repeat (8) @(posedge core_clk);
    reset_n <= 1'b1;
    rd(PSC_OFS_CTRL, 1'b1, {1'b0, 32'h1});
    rd(8'h10, 1'b1, {1'b1, 32'h0});
    send(6'h3f);
    for (int i = 0; i < 5; i++) send(6'($random(seed)));
    apb(1'b1, PSC_OFS_CTRL, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, PSC_OFS_PAR, 32'($random(seed)) & 32'h3f);
      repeat (3) @(posedge core_clk);
      ph_q.push_back(pwdata[5:0]);
    end
    apb(1'b1, PSC_OFS_CTRL, 32'h1);
    repeat (3) @(posedge core_clk);
    ph_q.push_back(prv);
    send(6'($random(seed)));
    apb(1'b1, 8'h10, 32'hffff);
    rd(PSC_OFS_WORD, 1'b1, {1'b0, 26'h0, prv});
    stop_test();
  end
endmodule : phase_shifter_control_port_test
`default_nettype wire
